/* File: verilog/dsp_port.sv */
// digital io port with sync inputs and master outputs, apb registers
//
// Operation
// (R1) input lines 1..16 form one word, line 1 the lsb
// (R2) lines 14, 15, 16 each selectable as digital or sync input
// (R3) software enables 1k pull-up on the auxiliary sync input
// (R4) software enables 360 ohm pull-down on conversion and start inputs
// (R5) line 15 in sync mode takes the conversion pulse from a neighbour
// (R6) line 16 in sync mode is an active-high start from a neighbour
// (R7) sixteen output lines as one word, low and high byte
// (R8) each output byte enabled or high impedance independently
// (R9) outputs high impedance after power-up unless strapped active
// (R10) conversion pulse output carries this module's conversion timing
// (R11) start output is active-high start for adjacent module
// (R12) software configures sync modes, starts master after the slaves
// (R13) software enables pull-downs on last slave of a chain
// (R14) no more than two slaves per chain
// (R15) a slave can also drive its own start and pulse outputs
// (R16) slave starts after start high, one conversion per pulse
// (R17) every asynchronous input passes two flip-flops before use
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module dsp_port
    import dsp_pkg::*;
#(
    parameter int PULSE_W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsp_pkg::ADDR_W-1:0] paddr,
    input wire logic [dsp_pkg::DATA_W-1:0] pwdata,
    output logic [dsp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] digital_input_pins,
    input wire logic strap_low_active,
    input wire logic strap_high_active,
    output logic [15:0] digital_output_word,
    output logic [1:0] digital_output_oe,
    output logic aux_sync_pullup_en,
    output logic conversion_pulse_pulldown_en,
    output logic start_pulldown_en,
    output logic conversion_pulse_output,
    output logic start_output,
    output logic conversion_strobe
);
    import dsp_pkg::*;

    logic [15:0] pins_s;
    logic [15:0] digital_input_word;
    logic [15:0] out_q;
    logic [1:0] oe_q;
    logic [2:0] sel_q;
    logic [2:0] pull_q;
    logic run_q;
    logic [31:0] period_q;
    logic [31:0] cnt_q;
    logic tick;
    logic [7:0] pw_q;
    logic conversion_pulse_output_q;
    logic start_out_q;
    logic conv_prev_q;
    logic slave_started_q;
    logic strobe_q;
    logic [1:0] strap_meta_q;
    logic [1:0] strap_q;
    logic strap_done_q;
    logic [1:0] strap_age_q;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] rdata_d;
    logic conversion_pulse_input;
    logic start_in;
    logic conv_edge;

    // (R17) pin synchroniser
    dsp_sync #(.W(16)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(digital_input_pins),
        .sync_out(pins_s)
    );

    // (R1) input word, line 1 at bit 0
    assign digital_input_word = pins_s;
    // (R5) (R6) sync functions read synchronised lines only when selected
    assign conversion_pulse_input = sel_q[SEL_CONV_BIT] & pins_s[LINE_CONV];
    assign start_in = sel_q[SEL_START_BIT] & pins_s[LINE_START];
    assign conv_edge = conversion_pulse_input & ~conv_prev_q;

    // apb decode: zero wait states, unmapped addresses raise pslverr
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    always_comb
    begin
        hit = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            OFS_INPUT:
            begin
                // (R2) lines in sync mode read as zero in the word
                rdata_d[15:0] = digital_input_word & ~{sel_q, 13'h0000};
            end
            OFS_OUTPUT: rdata_d[15:0] = out_q;
            OFS_OUT_EN: rdata_d[1:0] = oe_q;
            OFS_SYNC_SEL: rdata_d[2:0] = sel_q;
            OFS_PULL: rdata_d[2:0] = pull_q;
            OFS_MASTER: rdata_d = {period_q[30:0], run_q};
            OFS_STATUS:
            begin
                rdata_d[ST_STARTED_BIT] = slave_started_q;
                rdata_d[ST_AUX_BIT] = sel_q[SEL_AUX_BIT] & pins_s[LINE_AUX];
            end
            default: hit = 1'b0;
        endcase
    end

    // read data captured in setup, held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            if (rd_en)
            begin
                prdata <= rdata_d;
            end
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
        end
    end

    // (R7) output word and (R2) (R3) (R4) configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q <= OUTPUT_RST;
            sel_q <= SEL_RST;
            pull_q <= PULL_RST;
            run_q <= 1'b0;
            period_q <= PERIOD_RST;
        end
        else if (wr_en && pready == 1'b1)
        begin
            case (paddr)
                OFS_OUTPUT: out_q <= pwdata[15:0];
                OFS_SYNC_SEL: sel_q <= pwdata[2:0];
                OFS_PULL: pull_q <= pwdata[2:0];
                OFS_MASTER:
                begin
                    run_q <= pwdata[MST_RUN_BIT];
                    period_q <= {1'b0, pwdata[31:1]};
                end
                default: ;
            endcase
        end
    end

    // straps caught by clock after reset release, never by the reset itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_meta_q <= 2'h0;
            strap_q <= 2'h0;
        end
        else
        begin
            strap_meta_q <= {strap_high_active, strap_low_active};
            strap_q <= strap_meta_q;
        end
    end

    // (R8) (R9) per-byte output enable, high-z until strap or software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe_q <= 2'h0;
            strap_done_q <= 1'b0;
            strap_age_q <= 2'h0;
        end
        else if (!strap_done_q)
        begin
            // age shifts in ones; only the second stage is read, never the first
            strap_age_q <= {strap_age_q[0], 1'b1};
            if (strap_age_q[1])
            begin
                oe_q <= strap_q;
                strap_done_q <= 1'b1;
            end
        end
        else if (wr_en && pready && paddr == OFS_OUT_EN)
        begin
            oe_q <= pwdata[1:0];
        end
    end

    // master timing: period counter makes this module's conversion tick
    assign tick = run_q && (cnt_q >= period_q);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 32'h0000_0000;
        end
        else if (!run_q || tick)
        begin
            cnt_q <= 32'h0000_0000;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // (R16) slave waits for start high, then one strobe per conversion pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_prev_q <= 1'b0;
            slave_started_q <= 1'b0;
            strobe_q <= 1'b0;
        end
        else
        begin
            conv_prev_q <= conversion_pulse_input;
            if (!sel_q[SEL_START_BIT])
            begin
                slave_started_q <= 1'b0;
            end
            else if (start_in)
            begin
                slave_started_q <= 1'b1;
            end
            // slave follows received pulses; otherwise the local master tick
            if (sel_q[SEL_CONV_BIT])
            begin
                strobe_q <= conv_edge & (slave_started_q | ~sel_q[SEL_START_BIT]);
            end
            else
            begin
                strobe_q <= tick;
            end
        end
    end

    // (R10) (R11) (R15) outputs driven also when a slave, the pulse output then relaying received pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pw_q <= 8'h00;
            conversion_pulse_output_q <= 1'b0;
            start_out_q <= 1'b0;
        end
        else
        begin
            start_out_q <= run_q | slave_started_q;
            if (strobe_q)
            begin
                pw_q <= 8'(PULSE_W);
                conversion_pulse_output_q <= 1'b1;
            end
            else if (pw_q > 8'h01)
            begin
                pw_q <= pw_q - 8'h01;
            end
            else
            begin
                pw_q <= 8'h00;
                conversion_pulse_output_q <= 1'b0;
            end
        end
    end

    // pin-facing outputs registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            digital_output_word <= OUTPUT_RST;
            digital_output_oe <= 2'h0;
            aux_sync_pullup_en <= 1'b0;
            conversion_pulse_pulldown_en <= 1'b0;
            start_pulldown_en <= 1'b0;
            conversion_pulse_output <= 1'b0;
            start_output <= 1'b0;
            conversion_strobe <= 1'b0;
        end
        else
        begin
            digital_output_word <= out_q;
            digital_output_oe <= oe_q;
            // (R3) pull-up enable
            aux_sync_pullup_en <= pull_q[PULL_AUX_BIT];
            // (R4) pull-down enables
            conversion_pulse_pulldown_en <= pull_q[PULL_CONV_BIT];
            start_pulldown_en <= pull_q[PULL_START_BIT];
            conversion_pulse_output <= conversion_pulse_output_q;
            start_output <= start_out_q;
            conversion_strobe <= strobe_q;
        end
    end

    // (R17) a pin edge reaches the word no sooner than two edges later
    chk_sync_depth: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
        digital_input_word == $past(digital_input_pins, 2) || $past(!presetn, 2))
        else $error("input word not two stages behind pins");

    // (R16) no strobe before start seen in slave start mode
    chk_slave_gate: assert property (@(posedge pclk) disable iff (!presetn) // (R16)
        (sel_q == 3'h6 && !slave_started_q && $stable(sel_q)) |=> !strobe_q)
        else $error("strobe before start");

    // (R16) one strobe per received pulse edge
    chk_pulse_strobe: assert property (@(posedge pclk) disable iff (!presetn) // (R16)
        (conv_edge && sel_q[SEL_CONV_BIT] && !sel_q[SEL_START_BIT]) |=> strobe_q)
        else $error("pulse lost");

    // (R10) strobe drives the conversion output two cycles later
    chk_conversion_pulse_output: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
        strobe_q |=> ##1 conversion_pulse_output)
        else $error("conversion output missed");

    // (R11) running master raises start output
    chk_start_out: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
        run_q [*3] |-> start_output)
        else $error("start output low while running");

    // (R8) output enable follows its register
    chk_oe_follow: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
        digital_output_oe == $past(oe_q))
        else $error("output enable mismatch");

    // (R9) high impedance until straps are caught, then the straps decide
    chk_oe_reset: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
        (!strap_done_q |-> oe_q == 2'h0) and
        ($rose(strap_done_q) |-> oe_q == $past(strap_q)))
        else $error("output enable after reset wrong");

    // (R3) (R4) pull enables track register one cycle on
    chk_pull_en: assert property (@(posedge pclk) disable iff (!presetn) // (R4)
        $changed(pull_q) |=> {start_pulldown_en, conversion_pulse_pulldown_en,
        aux_sync_pullup_en} == $past(pull_q))
        else $error("pull enable mismatch");

    // (R7) output word registered from software value
    chk_out_word: assert property (@(posedge pclk) disable iff (!presetn) // (R7)
        digital_output_word == $past(out_q))
        else $error("output word mismatch");
endmodule

/* File: verilog/dsp_pkg.sv */
// constants for the digital io sync port
package dsp_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    // register byte offsets
    localparam logic [11:0] OFS_INPUT = 12'h000;
    localparam logic [11:0] OFS_OUTPUT = 12'h004;
    localparam logic [11:0] OFS_OUT_EN = 12'h008;
    localparam logic [11:0] OFS_SYNC_SEL = 12'h00c;
    localparam logic [11:0] OFS_PULL = 12'h010;
    localparam logic [11:0] OFS_MASTER = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    // field positions
    localparam int SEL_AUX_BIT = 0;
    localparam int SEL_CONV_BIT = 1;
    localparam int SEL_START_BIT = 2;
    localparam int PULL_AUX_BIT = 0;
    localparam int PULL_CONV_BIT = 1;
    localparam int PULL_START_BIT = 2;
    localparam int MST_RUN_BIT = 0;
    localparam int MST_PULSE_BIT = 1;
    localparam int ST_STARTED_BIT = 0;
    localparam int ST_AUX_BIT = 1;
    localparam int LINE_AUX = 13;
    localparam int LINE_CONV = 14;
    localparam int LINE_START = 15;
    // reset values and synchroniser depth
    localparam logic [15:0] OUTPUT_RST = 16'h0000;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [2:0] PULL_RST = 3'h0;
    localparam logic [31:0] PERIOD_RST = 32'h0000_0032;
    localparam int SYNC_STAGES = 2;
endpackage

/* File: verilog/dsp_sync.sv */
// two-stage synchroniser for a bus of asynchronous pins
`timescale 1ns/1ps
module dsp_sync #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: sim/dsp_far_end.sv */
// neighbouring master module and outside logic that drive the input pins
`timescale 1ns/1ps
module dsp_far_end (
    input wire logic pclk,
    input wire logic [15:0] data_word,
    input wire logic start_level,
    input wire logic pulse_go,
    output logic [15:0] pins
);
    logic [1:0] pulse_cnt_q = 2'h0;

    // conversion pulse, three cycles wide so the two-flop input stage cannot miss it
    always_ff @(posedge pclk)
    begin
        if (pulse_go)
            pulse_cnt_q <= 2'h3;
        else if (pulse_cnt_q != 2'h0)
            pulse_cnt_q <= pulse_cnt_q - 2'h1;
    end

    // one master drives start high-active; its outputs are always driven, never released
    assign pins = {data_word[15] | start_level, data_word[14] | (pulse_cnt_q != 2'h0),
        data_word[13:0]};
endmodule

/* File: sim/digital_io_sync_port_bench.sv */
// self-checking bench for the digital io sync port
`timescale 1ns/1ps
module digital_io_sync_port_bench;
    import dsp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_pulse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, seed;
    logic [15:0] pins, data_word, digital_output_word;
    logic strap_low_active, strap_high_active, start_level, pulse_go;
    logic [1:0] digital_output_oe;
    logic aux_sync_pullup_en, conversion_pulse_pulldown_en, start_pulldown_en;
    logic conversion_pulse_output, start_output, conversion_strobe;
    logic [33:0] note;
    logic [33:0] notes[$];
    int fail_count, tests_run, pulses, strobes, i;

    dsp_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .digital_input_pins(pins), .strap_low_active(strap_low_active),
        .strap_high_active(strap_high_active), .digital_output_word(digital_output_word),
        .digital_output_oe(digital_output_oe), .aux_sync_pullup_en(aux_sync_pullup_en),
        .conversion_pulse_pulldown_en(conversion_pulse_pulldown_en),
        .start_pulldown_en(start_pulldown_en), .conversion_pulse_output(conversion_pulse_output),
        .start_output(start_output), .conversion_strobe(conversion_strobe));

    dsp_far_end far_u (.pclk(pclk), .data_word(data_word), .start_level(start_level),
        .pulse_go(pulse_go), .pins(pins));

    // free-running 50 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; the expected answer is noted before the request goes out
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
        input logic err);
        notes.push_back({w, err, e});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    task pulse;
        pulse_go <= 1'b1;
        @(posedge pclk);
        pulse_go <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // runs the local master with period 9, i.e. one tick per 10 cycles
    task master_ticks;
        pulses = 0;
        wr(OFS_MASTER, {31'h9, 1'b1});
        repeat (100) @(posedge pclk);
        check("ticks", 32'(pulses >= 9 && pulses <= 10), 32'h1);
        check("start out", 32'(start_output), 32'h1);
        wr(OFS_MASTER, 32'h0);
    endtask

    // answer watcher: takes the oldest note whenever the slave completes a transfer
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            note = notes.pop_front();
            check("pslverr", 32'(pslverr), 32'(note[32]));
            if (!note[33])
                check("prdata", prdata, note[31:0]);
        end
    end

    // rising-edge counter for pulse output, high-cycle counter for local conversion strobe
    always @(posedge pclk)
    begin
        if (conversion_pulse_output === 1'b1 && last_pulse === 1'b0)
            pulses++;
        last_pulse = conversion_pulse_output;
        if (conversion_strobe === 1'b1)
            strobes++;
    end

    // watchdog: all scenarios need well under 5000 cycles
    initial
    begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        test_done();
    end

    initial
    begin
        seed = 32'h66b9;
        {psel, penable, pwrite, presetn, start_level, pulse_go, strap_high_active} = 7'h0;
        strap_low_active = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        data_word = 16'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // straps need two stages plus one edge, then one more to reach the pins
        repeat (6) @(posedge pclk);
        check("oe", 32'(digital_output_oe), 32'h1);
        rd(OFS_OUTPUT, 32'h0);
        rd(OFS_SYNC_SEL, 32'h0);
        rd(OFS_PULL, 32'h0);
        rd(OFS_MASTER, {PERIOD_RST[30:0], 1'b0});
        apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h020, 32'hffff_ffff, 32'h0, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            data_word <= rnd[15:0];
            repeat (4) @(posedge pclk);
            rd(OFS_INPUT, {16'h0, rnd[15:0]});
            wr(OFS_OUTPUT, {16'h0, rnd[31:16]});
            wr(OFS_OUT_EN, 32'(i));
            repeat (2) @(posedge pclk);
            check("dout", 32'(digital_output_word), {16'h0, rnd[31:16]});
            check("oe", 32'(digital_output_oe), 32'(i));
        end
        data_word <= {1'b0, rnd[14:0]};
        for (i = 0; i < 3; i++)
        begin
            wr(OFS_PULL, 32'(1 << i));
            wr(OFS_SYNC_SEL, 32'(1 << i));
            repeat (4) @(posedge pclk);
            check("pulls", {29'h0, start_pulldown_en, conversion_pulse_pulldown_en,
                aux_sync_pullup_en}, 32'(1 << i));
            rd(OFS_INPUT, 32'({1'b0, rnd[14:0]}) & ~32'(1 << (LINE_AUX + i)));
        end
        wr(OFS_SYNC_SEL, 32'h0);
        master_ticks();
        repeat (3) @(posedge pclk);
        check("start out", 32'(start_output), 32'h0);
        // last slave: pulls on, sync modes set before the master starts
        data_word <= {2'b00, rnd[13:0]};
        wr(OFS_PULL, 32'h6);
        wr(OFS_SYNC_SEL, 32'h6);
        strobes = 0;
        pulse();
        pulse();
        check("strobes", 32'(strobes), 32'h0);
        rd(OFS_STATUS, 32'h0);
        start_level <= 1'b1;
        repeat (4) @(posedge pclk);
        pulses = 0;
        for (i = 0; i < 3; i++)
            pulse();
        check("strobes", 32'(strobes), 32'h3);
        check("relayed pulses", 32'(pulses), 32'h3);
        rd(OFS_STATUS, 32'h1);
        check("start out", 32'(start_output), 32'h1);
        // started slave drops pulse following and masters its own chain
        wr(OFS_SYNC_SEL, 32'h4);
        master_ticks();
        test_done();
    end
endmodule
